// >>> swl_pkg.sv
// Constants and types shared by the serial wiper code loader.
// Assumes nothing beyond a SystemVerilog compiler.
package swl_pkg;
  // Serial word layout
  localparam int WORD_BITS = 11;
  localparam int ADDR_BITS = 3;
  localparam int CODE_BITS = 8;
  localparam int ADDR_POS  = 8;
  localparam int CODE_POS  = 0;
  // Reset, preset and shutdown values
  localparam logic [7:0]  MIDSCALE_CODE   = 8'h80;
  localparam logic [7:0]  ZERO_SCALE_CODE = 8'h00;
  localparam logic [10:0] SHIFT_RESET     = 11'h000;
  // Channel counts of the two variants
  localparam int FOUR_CHANNELS = 4;
  localparam int SIX_CHANNELS  = 6;
  typedef logic [CODE_BITS-1:0] swl_code_type;
  typedef logic [ADDR_BITS-1:0] swl_addr_type;
endpackage : swl_pkg

// >>> swl_link_if.sv
// Carrier between the serial-clock shifter and the core-clock loader.
// Word is written only on serial clock edges and is static while chip select is high.
interface swl_link_if;
  import swl_pkg::*;
  logic [WORD_BITS-1:0] word;
  logic                 sdo_bit;
  modport link (output word, output sdo_bit);
  modport core (input word, input sdo_bit);
endinterface : swl_link_if

// >>> swl_sync.sv
// Two flip-flop synchroniser for level signals.
// Assumes each bit is a level that holds for several destination clocks.
module swl_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Destination clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Level in and synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : swl_sync

// >>> swl_link_shifter.sv
// Input shifter and daisy-chain bit, clocked by the serial clock.
// Assumes chip select and serial data meet setup and hold to the serial clock.
module swl_link_shifter
  import swl_pkg::*;
(
  // Serial clock domain
  input  wire logic sclk,
  input  wire logic rstn,
  // Serial pins
  input  wire logic cs_n,
  input  wire logic serial_in,
  input  wire logic preset_n,
  // Toward the core domain
  swl_link_if.link  lnk
);
  logic [WORD_BITS-1:0] input_shifter;
  logic                 preset_s;

  swl_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_preset_sync (
    .clk  (sclk),
    .rstn (rstn),
    .d    (preset_n),
    .q    (preset_s)
  );

  // Shift one bit per rising edge while selected, else hold
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      input_shifter <= SHIFT_RESET;
    end else if (!cs_n) begin
      input_shifter <= {input_shifter[WORD_BITS-2:0], serial_in};
    end
  end

  // Oldest bit leaves for the next device in the chain
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      lnk.sdo_bit <= 1'b0;
    end else if (!preset_s) begin
      lnk.sdo_bit <= 1'b0;
    end else if (!cs_n) begin
      lnk.sdo_bit <= input_shifter[WORD_BITS-1];
    end
  end

  assign lnk.word = input_shifter;

  default clocking cb @(posedge sclk); endclocking
  default disable iff (!rstn);

  a_shift_in_bit:    assert property (!cs_n |=> input_shifter[0] == $past(serial_in))
    else $error("serial bit not shifted in");
  a_shift_hold_idle: assert property (cs_n |=> $stable(input_shifter))
    else $error("shifter moved while deselected");
  a_eleven_delay:    assert property ((!cs_n)[*8] ##1 (!cs_n)[*4] ##0 preset_s
                                      |=> lnk.sdo_bit == $past(serial_in, 12))
    else $error("serial out is not an eleven bit delay");
  c_full_word:       cover property ((!cs_n)[*8] ##1 (!cs_n)[*3] ##1 cs_n);
endmodule : swl_link_shifter

// >>> swl_wiper_loader.sv
// Serial wiper code loader: top of the digital potentiometer control logic.
// Assumes an outside controller drives chip select, serial clock and data.
module swl_wiper_loader
  import swl_pkg::*;
#(
  parameter int CHANNELS = SIX_CHANNELS
) (
  // Core clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  // Serial link
  input  wire logic                           sclk,
  input  wire logic                           cs_n,
  input  wire logic                           serial_in,
  output logic                                serial_out,
  output logic                                serial_out_oe,
  // Control pins
  input  wire logic                           preset_n,
  input  wire logic                           power_down_n,
  // Resistor ladder controls
  output logic      [CHANNELS-1:0][CODE_BITS-1:0] wiper_tap,
  output logic                                a_open
);

  generate
    if (CHANNELS != FOUR_CHANNELS && CHANNELS != SIX_CHANNELS) begin : g_bad_channels
      $error("CHANNELS must be 4 or 6");
    end
  endgenerate

  // Link-side logic on the serial clock
  swl_link_if lnk ();

  swl_link_shifter u_shifter (
    .sclk      (sclk),
    .rstn      (rstn),
    .cs_n      (cs_n),
    .serial_in (serial_in),
    .preset_n  (preset_n),
    .lnk       (lnk.link)
  );

  // Pin and cross-domain levels brought onto the core clock
  logic [3:0] raw_levels;
  logic [3:0] sync_levels;
  logic       cs_high;
  logic       preset_high;
  logic       power_up;
  logic       sdo_level;

  assign raw_levels = {cs_n, preset_n, power_down_n, lnk.sdo_bit};

  swl_sync #(.WIDTH(4), .RESET_VAL(4'he)) u_level_sync (
    .clk  (core_clk),
    .rstn (rstn),
    .d    (raw_levels),
    .q    (sync_levels)
  );

  assign cs_high     = sync_levels[3];
  assign preset_high = sync_levels[2];
  assign power_up    = sync_levels[1];
  assign sdo_level   = sync_levels[0];

  // Chip select edge detection
  logic cs_prev;
  logic cs_rise;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_high;
    end
  end

  assign cs_rise = cs_high && !cs_prev;

  // Word fields; the shifter is static once chip select is high
  swl_addr_type load_addr;
  swl_code_type load_code;
  logic         addr_mapped;
  logic         load_fire;

  assign load_addr   = lnk.word[ADDR_POS +: ADDR_BITS];
  assign load_code   = lnk.word[CODE_POS +: CODE_BITS];
  assign addr_mapped = int'(load_addr) < CHANNELS;
  // One load per framed word; shutdown and preset block it
  assign load_fire   = cs_rise && addr_mapped && preset_high && power_up;

  // Address decode: one enable per channel
  logic [CHANNELS-1:0] load_en;

  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_decode
      assign load_en[i] = load_fire && (int'(load_addr) == i);
    end
  endgenerate

  // Wiper code latches
  logic [CHANNELS-1:0][CODE_BITS-1:0] wiper_code_latch;

  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_latch
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          wiper_code_latch[i] <= MIDSCALE_CODE;
        end else if (!preset_high) begin
          wiper_code_latch[i] <= MIDSCALE_CODE;
        end else if (load_en[i]) begin
          wiper_code_latch[i] <= load_code;
        end
      end
    end
  endgenerate

  // Ladder controls; the latches are untouched by shutdown
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wiper_tap <= {CHANNELS{MIDSCALE_CODE}};
    end else if (!power_up) begin
      wiper_tap <= {CHANNELS{ZERO_SCALE_CODE}};
    end else begin
      wiper_tap <= wiper_code_latch;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      a_open <= 1'b0;
    end else begin
      a_open <= !power_up;
    end
  end

  // Open-drain serial output: drives only low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= 1'b0;
    end
  end

  // Pull low only while selected, powered, not preset, and the chain bit is 0.
  // Crossing adds core cycles, so a chained node needs a slow serial clock.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= !cs_high && power_up && preset_high && !sdo_level;
    end
  end

  // Checks on the core clock
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic [CHANNELS-1:0][CODE_BITS-1:0] all_mid;
  logic                               load_seen;
  swl_addr_type                       last_addr;
  swl_code_type                       last_code;

  assign all_mid = {CHANNELS{MIDSCALE_CODE}};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      load_seen <= 1'b0;
      last_addr <= '0;
      last_code <= '0;
    end else begin
      load_seen <= load_fire;
      if (load_fire) begin
        last_addr <= load_addr;
        last_code <= load_code;
      end
    end
  end

  a_load_addressed: assert property (load_seen |-> wiper_code_latch[last_addr] == last_code)
    else $error("addressed latch did not take the code");

  a_load_then_tap: assert property (load_fire && power_up
                                    ##1 power_up && preset_high ##1 power_up
                                    |-> wiper_tap[last_addr] == last_code)
    else $error("wiper tap did not follow the loaded code");

  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_check
      a_one_latch_moves: assert property ($changed(wiper_code_latch[i])
                                          |-> $past(load_en[i]) || !$past(preset_high))
        else $error("latch changed without its own enable");
    end
  endgenerate

  a_onehot_decode: assert property ($onehot0(load_en))
    else $error("more than one latch enabled");

  a_unmapped_kept: assert property (cs_rise && !addr_mapped |=> $stable(wiper_code_latch))
    else $error("unassigned address changed a latch");

  a_preset_level: assert property (!preset_high |=> wiper_code_latch == all_mid
                                   && !serial_out_oe)
    else $error("preset did not force midscale");

  a_preset_rise: assert property ($rose(preset_high) |-> wiper_code_latch == all_mid)
    else $error("latches not at 0x80 on preset release");

  a_shutdown_out: assert property (!power_up |=> a_open && !serial_out_oe
                                   && wiper_tap == '0)
    else $error("shutdown did not park the ladder");

  a_shutdown_keeps: assert property (!power_up && preset_high |=> $stable(wiper_code_latch))
    else $error("shutdown disturbed a latch");

  a_release_restore: assert property ($rose(power_up) |=> wiper_tap == $past(wiper_code_latch))
    else $error("setting not restored after shutdown");

  a_sdo_enable: assert property (!cs_high && power_up && preset_high && !sdo_level
                                 ##1 !cs_high |-> serial_out_oe)
    else $error("serial output not enabled while selected");

  a_open_drain: assert property (serial_out_oe |-> !serial_out && !cs_prev)
    else $error("serial output drove high");

  // Framing and latency helpers
  logic [2:0] since_rise;
  logic [1:0] frame_loads;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      since_rise <= 3'h7;
    end else if (cs_rise) begin
      since_rise <= 3'h0;
    end else if (since_rise != 3'h7) begin
      since_rise <= since_rise + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frame_loads <= 2'h0;
    end else if (!cs_high) begin
      frame_loads <= 2'h0;
    end else if (load_fire && frame_loads != 2'h3) begin
      frame_loads <= frame_loads + 2'h1;
    end
  end

  a_load_window: assert property ($changed(wiper_code_latch) && preset_high && $past(preset_high)
                                  |-> since_rise == 3'h0)
    else $error("latch changed away from a chip select rise");

  a_one_load_frame: assert property (frame_loads <= 2'h1)
    else $error("more than one load in a frame");

  a_tap_from_latch: assert property (power_up |=> wiper_tap == $past(wiper_code_latch))
    else $error("tap does not follow its latch");

  a_tap_holds: assert property (power_up && $past(power_up) && $stable(wiper_code_latch)
                                |=> $stable(wiper_tap))
    else $error("tap moved with a steady latch");

  a_idle_holds: assert property (!cs_rise && preset_high |=> $stable(wiper_code_latch))
    else $error("latch moved without a chip select rise");

  a_off_no_load: assert property (cs_rise && !power_up && preset_high
                                  |=> $stable(wiper_code_latch))
    else $error("load taken during shutdown");

  a_release_no_load: assert property ($rose(power_up) && preset_high && $past(preset_high)
                                      |-> $stable(wiper_code_latch))
    else $error("latch moved across shutdown release");

  a_preset_blocks_load: assert property (cs_rise && !preset_high |=> wiper_code_latch == all_mid)
    else $error("load taken during preset");

  a_preset_tap: assert property (!preset_high ##1 !preset_high && power_up
                                 |=> wiper_tap == all_mid)
    else $error("tap not at midscale during preset");

  // Output pin and address decode checks
  a_oe_preset_off: assert property (!preset_high |=> !serial_out_oe)
    else $error("serial output pulled during preset");

  a_open_follows: assert property (power_up |=> !a_open)
    else $error("A terminals open while powered");

  a_open_shut: assert property (!power_up |=> a_open)
    else $error("A terminals closed in shutdown");

  a_oe_deselect: assert property (cs_high |=> !serial_out_oe)
    else $error("serial output pulled while deselected");

  a_oe_tracks_bit: assert property (!cs_high && power_up && preset_high
                                    |=> serial_out_oe == !$past(sdo_level))
    else $error("serial output does not follow the chain bit");

  a_decode_map: assert property (load_fire |-> load_en == (CHANNELS'(1) << load_addr))
    else $error("address decoded to the wrong channel");

  a_unmapped_quiet: assert property (!addr_mapped |-> load_en == '0)
    else $error("unassigned address enabled a latch");

  // Per-channel load checks
  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_channel
      a_load_takes_code: assert property (load_en[i] |=> wiper_code_latch[i] == $past(load_code))
        else $error("enabled latch did not take the code");
      a_other_kept: assert property (load_fire && !load_en[i] && preset_high
                                     |=> $stable(wiper_code_latch[i]))
        else $error("latch moved on another channel load");
    end
  endgenerate

  c_load_word:   cover property (load_fire ##2 wiper_tap != all_mid);
  c_preset:      cover property (!preset_high ##1 preset_high);
  c_shutdown:    cover property (!power_up ##1 power_up);
  c_unmapped:    cover property (cs_rise && !addr_mapped);

endmodule : swl_wiper_loader

// >>> swl_host_model.sv
// Controller model: drives chip select, serial clock and data in frames.
// Assumes the bench feeds back the pulled-up daisy-chain node.
module swl_host_model (
  // Serial pins toward the device
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in,
  // Chain node as the next device sees it
  input  wire logic chain_node
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rx;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    rx = '0;
  end
  // One framed word of n bits, MSB first, half period h ns; clock idles low
  task automatic send(input logic [31:0] w, input int n, input int h);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #h sclk = 1'b1;
      #h sclk = 1'b0;
      rx = {rx[30:0], chain_node};
    end
    #h cs_n = 1'b1;
    serial_in = ~serial_in;
    #(h * 4);
  endtask : send
endmodule : swl_host_model

// >>> tb.sv
// Self-checking bench for the serial wiper code loader, six channels.
// Assumes the host model makes the link clock only inside frames.
module tb
  import swl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                core_clk;
  logic                rstn;
  logic                preset_n;
  logic                power_down_n;
  wire                 sclk;
  wire                 cs_n;
  wire                 serial_in;
  wire                 chain_node;
  logic                serial_out;
  logic                serial_out_oe;
  logic                a_open;
  logic [5:0][7:0]     wiper_tap;
  logic [5:0][7:0]     exp_tap;
  int                  bad_count;
  int                  samples_checked;
  // Open-drain node with pull-up
  assign chain_node = serial_out_oe ? serial_out : 1'b1;
  swl_wiper_loader #(.CHANNELS(SIX_CHANNELS)) dut (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .preset_n(preset_n), .power_down_n(power_down_n),
    .wiper_tap(wiper_tap), .a_open(a_open)
  );
  swl_host_model host (
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .chain_node(chain_node)
  );
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic frame(input logic [31:0] w, input int n);
    host.send(w, n, 24);
    settle(6);
  endtask : frame
  task automatic t_power_on;
    exp_tap = {6{8'h80}};
    check(wiper_tap, exp_tap);
    check(a_open, 1'b0);
    check(serial_out_oe, 1'b0);
    check(serial_out, 1'b0);
  endtask : t_power_on
  task automatic t_load_each;
    logic [7:0] code;
    for (int ch = 0; ch < 6; ch++) begin
      code = 8'(ch * 8'h33);
      exp_tap[ch] = code;
      frame({21'h0, 3'(ch), code}, 11);
      check(wiper_tap, exp_tap);
    end
  endtask : t_load_each
  task automatic t_long_frame;
    exp_tap[2] = 8'h5a;
    frame({17'h0, 4'ha, 3'd2, 8'h5a}, 15);
    check(wiper_tap, exp_tap);
  endtask : t_long_frame
  task automatic t_bad_addr;
    frame({21'h0, 3'd6, 8'h11}, 11);
    frame({21'h0, 3'd7, 8'h22}, 11);
    check(wiper_tap, exp_tap);
  endtask : t_bad_addr
  task automatic t_shutdown;
    power_down_n = 1'b0;
    settle(6);
    check(wiper_tap, '0);
    check(a_open, 1'b1);
    host.send(32'h0003ff, 22, 100);
    check(host.rx[10:0], 11'h7ff);
    @(posedge core_clk);
    #1 power_down_n = 1'b1;
    settle(6);
    check(wiper_tap, exp_tap);
    check(a_open, 1'b0);
  endtask : t_shutdown
  task automatic t_chain;
    host.send(32'h2d1c6, 22, 100);
    check(host.rx[10:0], 11'h05a);
    exp_tap[1] = 8'hc6;
    settle(6);
    check(wiper_tap, exp_tap);
  endtask : t_chain
  task automatic t_preset;
    preset_n = 1'b0;
    settle(6);
    exp_tap = {6{8'h80}};
    check(wiper_tap, exp_tap);
    check(serial_out_oe, 1'b0);
    @(posedge core_clk);
    #1 preset_n = 1'b1;
    settle(6);
    check(wiper_tap, exp_tap);
  endtask : t_preset
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    #100us;
    bad_count++;
    summarize();
  end
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rstn = 1'b0;
    preset_n = 1'b1;
    power_down_n = 1'b1;
    exp_tap = '0;
    repeat (3) @(posedge core_clk);
    #1 rstn = 1'b1;
    settle(4);
    t_power_on();
    t_load_each();
    t_long_frame();
    t_bad_addr();
    t_shutdown();
    t_chain();
    t_preset();
    summarize();
  end
endmodule : tb
